// >>> rtl/pcc_pkg.sv
/*
 * Constants for the PWM cycle configuration register: address, field positions,
 * reset value, compare byte addresses and the cycle length mask helper.
 * Assumes an 8-bit special function register bus with byte addresses.
 */
package pcc_pkg;

    // Register address and reset value
    localparam logic [7:0] CFG_ADDR  = 8'hF7;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Field positions inside the register
    localparam int BANK_BIT   = 7;
    localparam int IRQEN_BIT  = 6;
    localparam int FLAG_BIT   = 5;
    localparam int UNUSED_BIT = 4;
    localparam int WIDE_BIT   = 3;
    localparam int LEN_LSB    = 0;
    localparam int LEN_W      = 3;

    // Shared compare byte addresses, channel index added to the base
    localparam logic [7:0] CMP_LO_BASE = 8'hA0;
    localparam logic [7:0] CMP_HI_BASE = 8'hB0;

    // Channel count and cycle length of code zero
    localparam int          NCH_DEFAULT = 3;
    localparam logic [3:0]  BASE_LEN    = 4'h8;

    // Mask of the low 8 + code bits of the counter
    function automatic logic [15:0] len_mask(input logic [LEN_W-1:0] code);
        len_mask = 16'hFFFF >> (BASE_LEN - {1'b0, code});
    endfunction : len_mask

endpackage : pcc_pkg

// >>> rtl/pcc_bank_if.sv
/*
 * Carrier between the register block and its compare bank steering module.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface pcc_bank_if #(
    parameter int NCH = pcc_pkg::NCH_DEFAULT,
    parameter int CHW = (NCH > 1) ? $clog2(NCH) : 1
);
    logic            acc_wr;
    logic            acc_hi;
    logic [CHW-1:0]  acc_chan;
    logic [7:0]      acc_wdata;
    logic            bank_sel;
    logic            cc_wr;
    logic            ar_wr;
    logic [15:0]     ar_value [NCH];

    modport top  (output acc_wr, acc_hi, acc_chan, acc_wdata, bank_sel,
                  input  cc_wr, ar_wr, ar_value);
    modport bank (input  acc_wr, acc_hi, acc_chan, acc_wdata, bank_sel,
                  output cc_wr, ar_wr, ar_value);
endinterface : pcc_bank_if

`default_nettype wire

// >>> rtl/pcc_bank_steer.sv
/*
 * Steers compare byte writes to the capture/compare bank or to the
 * auto-reload bank, and holds the auto-reload registers.
 * Assumes the top module decodes the compare addresses.
 */
`timescale 1ns/1ps
`default_nettype none

module pcc_bank_steer #(
    parameter int NCH = pcc_pkg::NCH_DEFAULT
) (
    // Clock and reset
    input  wire logic  ref_clk,
    input  wire logic  reset_n,
    // Link to the register block
    pcc_bank_if.bank   bus
);

    logic [15:0] ar_mem_ff [NCH];

    // Bank choice of a compare write
    always_comb begin
        bus.cc_wr = bus.acc_wr & ~bus.bank_sel;
        bus.ar_wr = bus.acc_wr & bus.bank_sel;
    end

    // Auto-reload storage, byte wide writes
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < NCH; i++) ar_mem_ff[i] <= 16'h0000;
        end else if (bus.ar_wr) begin
            for (int i = 0; i < NCH; i++) begin
                if (int'(bus.acc_chan) == i) begin
                    if (bus.acc_hi) ar_mem_ff[i][15:8] <= bus.acc_wdata;
                    else            ar_mem_ff[i][7:0]  <= bus.acc_wdata;
                end
            end
        end
    end

    // Stored values to the register block
    always_comb begin
        for (int i = 0; i < NCH; i++) bus.ar_value[i] = ar_mem_ff[i];
    end

    a_bank_exclusive: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !bus.ar_wr |=> $stable(ar_mem_ff[0]))
        else $error("reload store changed without a bank 1 write");

    a_reload_store: assert property (@(posedge ref_clk) disable iff (!reset_n)
        bus.acc_wr && bus.bank_sel && !bus.acc_hi && bus.acc_chan == '0
        |=> ar_mem_ff[0][7:0] == $past(bus.acc_wdata))
        else $error("auto-reload low byte not stored");

endmodule : pcc_bank_steer

`default_nettype wire

// >>> rtl/pcc_top.sv
/*
 * PWM cycle configuration register of the counter array: bank select for
 * the shared compare addresses, cycle length, wide reload enable, cycle
 * overflow flag and its interrupt mask.
 * Assumes a synchronous SFR bus with one-cycle read and write strobes, and
 * a main counter value sampled every clock.
 */
// Contract
// - Bank select 0 sends compare byte accesses to capture/compare, 1 to auto-reload.
// - Auto-reload values feed channels in 9 to 15 bit PWM and in 16-bit PWM.
// - In all other channel modes the auto-reload values have no effect.
// - The interrupt is requested while the overflow flag is set only if enabled.
// - The overflow flag is set when bit n (9 to 15) of the main counter overflows.
// - The cycle length select field picks which counter bit sets the flag.
// - Hardware or a software write of 1 sets the flag; only software clears it.
// - The flag stays 1 after an overflow until software clears it.
// - Length codes 000 to 111 give cycle lengths of 8 to 15 bits.
// - Channels in 16-bit PWM mode ignore the cycle length select field.
// - Bit 4 reads as 0 and ignores writes.
`timescale 1ns/1ps
`default_nettype none

module pcc_top #(
    parameter int NCH = pcc_pkg::NCH_DEFAULT,
    parameter int CHW = (NCH > 1) ? $clog2(NCH) : 1
) (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    // SFR bus
    input  wire logic [7:0]          sfr_addr,
    input  wire logic [7:0]          sfr_wdata,
    input  wire logic                sfr_wr,
    input  wire logic                sfr_rd,
    output logic      [7:0]          sfr_rdata,
    // Main counter and channel modes
    input  wire logic [15:0]         main_array_counter,
    input  wire logic [NCH-1:0]      chan_pwm_en,
    input  wire logic [NCH-1:0]      chan_pwm16,
    input  wire logic [NCH*16-1:0]   cc_value,
    // Configuration outputs
    output logic                     reload_bank_select,
    output logic                     wide_pwm_reload_enable,
    output logic [2:0]               cycle_length_select,
    output logic                     cycle_overflow_flag,
    output logic                     pca_irq,
    // Capture/compare write port
    output logic                     cc_wr_stb,
    output logic                     cc_wr_hi,
    output logic [CHW-1:0]           cc_wr_chan,
    output logic [7:0]               cc_wr_data,
    // Reload values per channel
    output logic [NCH*16-1:0]        reload_value,
    output logic [NCH-1:0]           reload_valid
);

    logic                 bank_ff;
    logic                 irqen_ff;
    logic                 flag_ff;
    logic                 wide_ff;
    logic [2:0]           len_ff;
    logic                 irq_ff;
    logic [7:0]           rdata_ff;
    logic [15:0]          cnt_prev_ff;
    logic                 cc_stb_ff;
    logic                 cc_hi_ff;
    logic [CHW-1:0]       cc_chan_ff;
    logic [7:0]           cc_data_ff;
    logic [NCH*16-1:0]    rl_value_ff;
    logic [NCH-1:0]       rl_valid_ff;

    logic                 cfg_hit;
    logic                 cfg_wr;
    logic                 cmp_hit;
    logic                 cmp_hi;
    logic [CHW-1:0]       cmp_chan;
    logic [15:0]          len_m;
    logic                 ovf_event;
    logic                 nxt_flag;
    logic [7:0]           nxt_rdata;
    logic [7:0]           cfg_view;
    logic [15:0]          sel_word;

    pcc_bank_if #(.NCH(NCH), .CHW(CHW)) bank_bus ();

    pcc_bank_steer #(.NCH(NCH)) u_bank (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .bus     (bank_bus.bank)
    );

    // Address decode of the register and compare bytes
    always_comb begin
        cfg_hit  = (sfr_addr == pcc_pkg::CFG_ADDR);
        cfg_wr   = sfr_wr & cfg_hit;
        cmp_hit  = 1'b0;
        cmp_hi   = 1'b0;
        cmp_chan = '0;
        for (int i = 0; i < NCH; i++) begin
            if (sfr_addr == pcc_pkg::CMP_LO_BASE + 8'(i)) begin
                cmp_hit  = 1'b1;
                cmp_chan = CHW'(i);
            end
            if (sfr_addr == pcc_pkg::CMP_HI_BASE + 8'(i)) begin
                cmp_hit  = 1'b1;
                cmp_hi   = 1'b1;
                cmp_chan = CHW'(i);
            end
        end
    end

    // Compare byte access handed to the bank steering
    always_comb begin
        bank_bus.acc_wr    = sfr_wr & cmp_hit;
        bank_bus.acc_hi    = cmp_hi;
        bank_bus.acc_chan  = cmp_chan;
        bank_bus.acc_wdata = sfr_wdata;
        bank_bus.bank_sel  = bank_ff;
    end

    // Control fields written by software
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            bank_ff  <= pcc_pkg::CFG_RESET[pcc_pkg::BANK_BIT];
            irqen_ff <= pcc_pkg::CFG_RESET[pcc_pkg::IRQEN_BIT];
            wide_ff  <= pcc_pkg::CFG_RESET[pcc_pkg::WIDE_BIT];
            len_ff   <= pcc_pkg::CFG_RESET[pcc_pkg::LEN_LSB +: pcc_pkg::LEN_W];
        end else if (cfg_wr) begin
            bank_ff  <= sfr_wdata[pcc_pkg::BANK_BIT];
            irqen_ff <= sfr_wdata[pcc_pkg::IRQEN_BIT];
            wide_ff  <= sfr_wdata[pcc_pkg::WIDE_BIT];
            len_ff   <= sfr_wdata[pcc_pkg::LEN_LSB +: pcc_pkg::LEN_W];
        end
    end

    // Overflow of bit 8+code: low bits wrap from all ones to zero
    always_comb begin
        len_m     = pcc_pkg::len_mask(len_ff);
        ovf_event = (len_ff != 3'h0)
                  && ((cnt_prev_ff & len_m) == len_m)
                  && ((main_array_counter & len_m) == 16'h0000);
    end

    // Sticky flag: hardware set wins over a software clear
    always_comb begin
        nxt_flag = flag_ff;
        if (cfg_wr) nxt_flag = sfr_wdata[pcc_pkg::FLAG_BIT];
        if (ovf_event) nxt_flag = 1'b1;
    end

    // Counter history and flag
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cnt_prev_ff <= 16'h0000;
            flag_ff     <= pcc_pkg::CFG_RESET[pcc_pkg::FLAG_BIT];
        end else begin
            cnt_prev_ff <= main_array_counter;
            flag_ff     <= nxt_flag;
        end
    end

    // Interrupt request gated by the enable
    always_ff @(posedge ref_clk) begin
        if (!reset_n) irq_ff <= 1'b0;
        else          irq_ff <= flag_ff & irqen_ff;
    end

    // Read data mux
    always_comb begin
        cfg_view = {bank_ff, irqen_ff, flag_ff, 1'b0, wide_ff, len_ff};
        sel_word = bank_ff ? bank_bus.ar_value[cmp_chan]
                           : cc_value[cmp_chan*16 +: 16];
        if (cfg_hit)      nxt_rdata = cfg_view;
        else if (cmp_hit) nxt_rdata = cmp_hi ? sel_word[15:8] : sel_word[7:0];
        else              nxt_rdata = 8'h00;
    end

    // Registered read data
    always_ff @(posedge ref_clk) begin
        if (!reset_n)    rdata_ff <= 8'h00;
        else if (sfr_rd) rdata_ff <= nxt_rdata;
    end

    // Capture/compare write port, one cycle after the bus write
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cc_stb_ff  <= 1'b0;
            cc_hi_ff   <= 1'b0;
            cc_chan_ff <= '0;
            cc_data_ff <= 8'h00;
        end else begin
            cc_stb_ff <= bank_bus.cc_wr;
            if (bank_bus.cc_wr) begin
                cc_hi_ff   <= cmp_hi;
                cc_chan_ff <= cmp_chan;
                cc_data_ff <= sfr_wdata;
            end
        end
    end

    // Reload value per channel by its mode
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rl_value_ff <= '0;
            rl_valid_ff <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (chan_pwm16[i]) begin
                    rl_valid_ff[i]          <= wide_ff;
                    rl_value_ff[i*16 +: 16] <= wide_ff ? bank_bus.ar_value[i] : 16'h0000;
                end else if (chan_pwm_en[i] && len_ff != 3'h0) begin
                    rl_valid_ff[i]          <= 1'b1;
                    rl_value_ff[i*16 +: 16] <= bank_bus.ar_value[i] & len_m;
                end else begin
                    rl_valid_ff[i]          <= 1'b0;
                    rl_value_ff[i*16 +: 16] <= 16'h0000;
                end
            end
        end
    end

    // Outputs straight from flip-flops
    assign sfr_rdata              = rdata_ff;
    assign reload_bank_select     = bank_ff;
    assign wide_pwm_reload_enable = wide_ff;
    assign cycle_length_select    = len_ff;
    assign cycle_overflow_flag    = flag_ff;
    assign pca_irq                = irq_ff;
    assign cc_wr_stb              = cc_stb_ff;
    assign cc_wr_hi               = cc_hi_ff;
    assign cc_wr_chan             = cc_chan_ff;
    assign cc_wr_data             = cc_data_ff;
    assign reload_value           = rl_value_ff;
    assign reload_valid           = rl_valid_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_sw_clear;
        cfg_wr && !sfr_wdata[pcc_pkg::FLAG_BIT] && !ovf_event;
    endsequence

    sequence s_flag_held;
        flag_ff && !(cfg_wr && !sfr_wdata[pcc_pkg::FLAG_BIT]);
    endsequence

    a_flag_hw_set: assert property (ovf_event |=> flag_ff)
        else $error("overflow did not set the flag");
    a_flag_no_mask: assert property (ovf_event && !irqen_ff |=> flag_ff && !irqen_ff)
        else $error("flag not set while interrupt disabled");
    a_flag_sw_set: assert property (cfg_wr && sfr_wdata[pcc_pkg::FLAG_BIT] |=> flag_ff)
        else $error("software write of 1 did not set the flag");
    a_flag_sw_clear: assert property (s_sw_clear |=> !flag_ff)
        else $error("software clear did not clear the flag");
    a_flag_sticky: assert property (s_flag_held |=> flag_ff)
        else $error("flag dropped without a clear");
    a_irq_gated: assert property (flag_ff && irqen_ff |=> pca_irq)
        else $error("enabled flag raised no interrupt");
    a_irq_masked: assert property (!irqen_ff ##1 !irqen_ff |-> !pca_irq)
        else $error("interrupt raised while disabled");
    a_unused_zero: assert property (sfr_rd && cfg_hit |=> sfr_rdata[pcc_pkg::UNUSED_BIT] == 1'b0)
        else $error("unused bit read as one");
    a_cc_route: assert property (sfr_wr && cmp_hit && !bank_ff |=> cc_wr_stb)
        else $error("bank 0 write missed the capture/compare port");
    a_ar_route: assert property (sfr_wr && cmp_hit && bank_ff |=> !cc_wr_stb)
        else $error("bank 1 write reached the capture/compare port");
    a_reload_idle: assert property (!chan_pwm_en[0] && !chan_pwm16[0] |=> !reload_valid[0])
        else $error("reload valid in a non PWM mode");
    a_wide_ignores_len: assert property (chan_pwm16[0] && wide_ff
        |=> reload_valid[0] && reload_value[15:0] == $past(bank_bus.ar_value[0]))
        else $error("16-bit reload value masked by cycle length");
    a_len_select: assert property (chan_pwm_en[0] && !chan_pwm16[0] && len_ff == 3'h3
        |=> reload_value[15:11] == 5'h00)
        else $error("11-bit reload value not masked");

endmodule : pcc_top

`default_nettype wire

// >>> tb/tb.sv
/*
 * Self-checking bench for the PWM cycle configuration register block.
 * Assumes pcc_pkg and the design files are compiled first; the bench drives
 * the SFR bus, the main counter and the channel modes itself.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int NCH = 3;
    localparam int CHW = 2;

    // Design ports
    logic                ref_clk;
    logic                reset_n;
    logic [7:0]          sfr_addr;
    logic [7:0]          sfr_wdata;
    logic                sfr_wr;
    logic                sfr_rd;
    logic [7:0]          sfr_rdata;
    logic [15:0]         main_array_counter;
    logic [NCH-1:0]      chan_pwm_en;
    logic [NCH-1:0]      chan_pwm16;
    logic [NCH*16-1:0]   cc_value;
    logic                reload_bank_select;
    logic                wide_pwm_reload_enable;
    logic [2:0]          cycle_length_select;
    logic                cycle_overflow_flag;
    logic                pca_irq;
    logic                cc_wr_stb;
    logic                cc_wr_hi;
    logic [CHW-1:0]      cc_wr_chan;
    logic [7:0]          cc_wr_data;
    logic [NCH*16-1:0]   reload_value;
    logic [NCH-1:0]      reload_valid;
    // Bench bookkeeping
    int                  error_cnt = 0;
    int                  total_checks = 0;
    int                  cycles = 0;
    logic                rd_pend = 1'b0;
    logic [7:0]          rd_q [$];
    logic [10:0]         cc_q [$];
    logic [7:0]          lo;
    logic [7:0]          hi;

    pcc_top #(.NCH(NCH), .CHW(CHW)) u_pcc_top (
        .ref_clk, .reset_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
        .main_array_counter, .chan_pwm_en, .chan_pwm16, .cc_value,
        .reload_bank_select, .wide_pwm_reload_enable, .cycle_length_select,
        .cycle_overflow_flag, .pca_irq, .cc_wr_stb, .cc_wr_hi, .cc_wr_chan,
        .cc_wr_data, .reload_value, .reload_valid
    );

    // Clock at 100 ns
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    // One write cycle, a free edge before it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge ref_clk);
        sfr_wr    <= 1'b0;
    endtask : wr

    // One read cycle, expected byte noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        rd_q.push_back(exp);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge ref_clk);
        sfr_rd   <= 1'b0;
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle

    // Counter step from all ones to all zero in the low bits of m, bit above m kept 0
    task automatic step(input logic [15:0] m);
        logic [15:0] v;
        v = m | (~(m | (m + 16'h0001)) & 16'($urandom));
        @(posedge ref_clk);
        main_array_counter <= v;
        @(posedge ref_clk);
        main_array_counter <= v + 16'h0001;
    endtask : step

    // Overflow at length code l, interrupt enable en
    task automatic ovf(input int l, input logic en);
        logic [15:0] m;
        logic [7:0]  cfg;
        m   = 16'((32'h1 << (8 + l)) - 1);
        cfg = {1'b0, en, 3'b000, 3'(l)};
        wr(8'hF7, cfg);
        idle(1);
        check("len", 16'(cycle_length_select), 16'(l));
        if (l > 0) begin
            step(m >> 1);
            idle(3);
            rd(8'hF7, cfg);
        end
        step(m);
        idle(3);
        check("irq", 16'(pca_irq), 16'(en && l > 0));
        check("flag", 16'(cycle_overflow_flag), 16'(l > 0));
        rd(8'hF7, cfg | ((l > 0) ? 8'h20 : 8'h00));
        idle(4);
        rd(8'hF7, cfg | ((l > 0) ? 8'h20 : 8'h00));
        wr(8'hF7, cfg);
        idle(2);
        rd(8'hF7, cfg);
        check("irq clear", 16'(pca_irq), 16'h0000);
    endtask : ovf

    // Read results and compare strobes against the oldest notes
    always @(posedge ref_clk) begin
        if (rd_pend) begin
            if (rd_q.size() == 0) check("rd_q", 16'h0001, 16'h0000);
            else check("sfr_rdata", 16'(sfr_rdata), 16'(rd_q.pop_front()));
        end
        rd_pend = sfr_rd;
        if (cc_wr_stb === 1'b1) begin
            if (cc_q.size() == 0) check("cc_wr_stb", 16'h0001, 16'h0000);
            else check("cc_wr", 16'({cc_wr_hi, cc_wr_chan, cc_wr_data}), 16'(cc_q.pop_front()));
        end
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 8000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // Main sequence
    initial begin
        reset_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        main_array_counter = 16'h0000;
        chan_pwm_en = '0;
        chan_pwm16 = '0;
        void'($urandom(67));
        cc_value = {16'($urandom), 16'($urandom), 16'($urandom)};
        idle(10);
        reset_n <= 1'b1;
        idle(1);
        check("outs", 16'({reload_bank_select, wide_pwm_reload_enable, cycle_length_select,
              cycle_overflow_flag, pca_irq, cc_wr_stb, reload_valid}), 16'h0000);
        rd(8'hF7, 8'h00);
        // Unused bit, software set of the flag, unmapped address
        wr(8'hF7, 8'h1F);
        rd(8'hF7, 8'h0F);
        wr(8'hF6, 8'hFF);
        rd(8'hF7, 8'h0F);
        rd(8'hF6, 8'h00);
        wr(8'hF7, 8'h20);
        idle(2);
        check("irq masked", 16'(pca_irq), 16'h0000);
        rd(8'hF7, 8'h20);
        wr(8'hF7, 8'h60);
        idle(2);
        check("irq set", 16'(pca_irq), 16'h0001);
        wr(8'hF7, 8'h40);
        rd(8'hF7, 8'h40);
        for (int l = 0; l < 8; l++) ovf(l, 1'(l));
        // Bank 0 compare writes and reads
        wr(8'hF7, 8'h00);
        for (int c = 0; c < NCH; c++) begin
            lo = 8'($urandom);
            cc_q.push_back({1'b1, 2'(c), lo});
            wr(8'hB0 + 8'(c), lo);
            cc_q.push_back({1'b0, 2'(c), ~lo});
            wr(8'hA0 + 8'(c), ~lo);
        end
        rd(8'hA2, cc_value[39:32]);
        rd(8'hB1, cc_value[31:24]);
        // Bank 1 writes land in the reload store
        wr(8'hF7, 8'h88);
        lo = 8'($urandom);
        hi = 8'($urandom);
        wr(8'hA0, lo);
        wr(8'hB0, hi);
        rd(8'hB0, hi);
        rd(8'hA0, lo);
        check("bank sel", 16'({reload_bank_select, wide_pwm_reload_enable}), 16'h0003);
        @(posedge ref_clk);
        chan_pwm16 <= 3'b001;
        idle(3);
        check("rl16 valid", 16'(reload_valid), 16'h0001);
        check("rl16 value", reload_value[15:0], {hi, lo});
        check("rl other", reload_value[47:16] == 32'h0, 16'h0001);
        wr(8'hF7, 8'h8B);
        idle(3);
        check("rl16 len", reload_value[15:0], {hi, lo});
        @(posedge ref_clk);
        chan_pwm16 <= 3'b000;
        chan_pwm_en <= 3'b001;
        idle(3);
        check("rl11 valid", 16'(reload_valid), 16'h0001);
        check("rl11 value", reload_value[15:0], {hi, lo} & 16'h07FF);
        wr(8'hF7, 8'h80);
        idle(3);
        check("rl8 valid", 16'(reload_valid), 16'h0000);
        // Reset in mid-run clears the register
        wr(8'hF7, 8'h65);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        idle(2);
        reset_n <= 1'b1;
        rd(8'hF7, 8'h00);
        idle(3);
        check("rd_q empty", 16'(rd_q.size()), 16'h0000);
        check("cc_q empty", 16'(cc_q.size()), 16'h0000);
        wrap_up();
    end

endmodule : tb

`default_nettype wire
